// *** bench/hcsc_hall_model.sv ***
`timescale 1ns/100ps
module hcsc_hall_model (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // one-cycle step requests
    input wire logic fwd_in,
    input wire logic rev_in,
    // sensor levels, driven at all times
    output logic [2:0] hall_out
);
    logic [2:0] pos_q;
    // one sensor changes per step, along increasing electrical angle
    always_comb begin
        case (pos_q)
            3'h0: hall_out = 3'h1;
            3'h1: hall_out = 3'h3;
            3'h2: hall_out = 3'h2;
            3'h3: hall_out = 3'h6;
            3'h4: hall_out = 3'h4;
            default: hall_out = 3'h5;
        endcase
    end
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            pos_q <= 3'h0;
        end else if (fwd_in) begin
            pos_q <= (pos_q == 3'h5) ? 3'h0 : pos_q + 3'h1;
        end else if (rev_in) begin
            pos_q <= (pos_q == 3'h0) ? 3'h5 : pos_q - 3'h1;
        end
    end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %0h want %0h", $time, g, e); end end
module tb_top;
    // short tick so that periods stay small
    localparam int TDIV = 2;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wdata_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rdata_out;
    logic [2:0] hall;
    logic fwd = 1'b0;
    logic rev = 1'b0;
    hcsc_pkg::hcsc_phase_s [2:0] phase_out;
    hcsc_pkg::hcsc_fract_t speed_out;
    logic dir_out;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    int next_cyc, pos, k, secm;
    int gap[32];
    logic [31:0] scale;
    logic [31:0] ledge = 32'h0;
    logic [1:0] eb[3] = '{2'h2, 2'h2, 2'h2};
    logic [1:0] ec[3] = '{2'h2, 2'h2, 2'h2};
    logic ei[3] = '{1'b0, 1'b0, 1'b0};
    logic [23:0] duty = 24'h0;
    logic [2:0] seq[6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    logic [31:0] gin[5] = '{32'h0040_0000, 32'h0280_0000, 32'hFF80_0000, 32'h007F_FFFF,
        32'h0080_0000};
    logic [31:0] gout[5] = '{32'h0040_0000, 32'h0102_8000, 32'h0080_0000, 32'h007F_FFFF,
        32'h0100_8000};

    hcsc_hall_model i_hall (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .fwd_in(fwd),
        .rev_in(rev), .hall_out(hall));
    hcsc_top #(.NUM_PHASES(3), .TICK_DIV(TDIV)) i_dut (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .hall_in(hall), .phase_out(phase_out), .speed_out(speed_out), .dir_out(dir_out));

    initial begin
        forever #20 sys_clk_in = ~sys_clk_in;
    end
    // the whole run needs well under 3000 cycles
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            conclude();
        end
    end

    task automatic conclude();
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge sys_clk_in);
        d = reg_rdata_out;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        `CHK(d, e)
    endtask
    // even index turns the input's own phase off, odd turns the next one on, or the previous one from index 12 up
    function automatic logic [31:0] cmd(input int i);
        int inp, r, ph;
        inp = (i % 12) / 4;
        r = (i / 2) % 2;
        ph = (i % 2 == 0) ? inp : (i >= 12) ? (inp + 2) % 3 : (inp + 1) % 3;
        if (i % 2 == 0)
            return {8'(ph), r ? 8'h03 : 8'h02, r ? 8'h02 : 8'h03, 8'(1 - r)};
        return {8'(ph), r ? 8'h00 : 8'h01, r ? 8'h01 : 8'h00, 8'(r)};
    endfunction
    task automatic apply(input int i);
        logic [31:0] w;
        w = cmd(i);
        eb[w[31:24]] = w[17:16];
        ec[w[31:24]] = w[9:8];
        if (i % 2 == 1) ei[w[31:24]] = w[0];
    endtask
    task automatic chk_ph();
        for (int p = 0; p < 3; p++) begin
            `CHK(phase_out[p].base_st, eb[p])
            `CHK(phase_out[p].comp_st, ec[p])
            `CHK(phase_out[p].duty_invert_sign, ei[p])
            `CHK(phase_out[p].duty, ei[p] ? (duty == 24'h800000 ? 24'h7FFFFF : -duty) : duty)
        end
    endtask
    task automatic step(input logic r, input int g, input logic ph_ok, input logic per_ok);
        logic [2:0] o, n;
        int inp, i, p;
        logic [31:0] w;
        o = seq[pos];
        pos = r ? (pos + 5) % 6 : (pos + 1) % 6;
        n = seq[pos];
        inp = ((o ^ n) == 3'h1) ? 0 : ((o ^ n) == 3'h2) ? 1 : 2;
        i = (r ? 12 : 0) + 4 * inp + 2 * n[inp];
        next_cyc += g;
        wait (cyc == next_cyc);
        fwd <= ~r;
        rev <= r;
        @(posedge sys_clk_in);
        fwd <= 1'b0;
        rev <= 1'b0;
        apply(i);
        apply(i + 1);
        gap[k] = g / TDIV;
        repeat (40) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        if (ph_ok) chk_ph();
        `CHK(dir_out, r)
        chk_rd(hcsc_pkg::ADDR_STATUS, {28'h0, 3'(pos), r});
        // edge times are only known relative to each other, so each one is judged by the last
        rd(hcsc_pkg::ADDR_LAST_EDGE, w);
        if (k > 0) `CHK(w, ledge + 32'(gap[k]))
        ledge = w;
        if (k > 0) chk_rd(hcsc_pkg::ADDR_SECT_PER, 32'(gap[k]));
        p = 0;
        for (int j = 0; j < 6 && j <= k; j++) p += gap[k - j];
        if (per_ok) chk_rd(hcsc_pkg::ADDR_REV_PER, 32'(p));
        if (secm) p = gap[k];
        if (per_ok || secm) `CHK(speed_out, (scale / p > 32'h7FFFFF) ? 24'h7FFFFF : 24'(scale / p))
        k++;
    endtask

    initial begin
        pos = 0;
        k = 0;
        secm = 0;
        repeat (5) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        @(negedge sys_clk_in);
        chk_ph();
        `CHK(speed_out, 24'h0)
        chk_rd(hcsc_pkg::ADDR_CTRL, hcsc_pkg::CTRL_RESET);
        chk_rd(hcsc_pkg::ADDR_SCALE, hcsc_pkg::SCALE_RESET);
        chk_rd(8'hFC, 32'h0);
        for (int j = 0; j < 5; j++) begin
            wr(hcsc_pkg::ADDR_GAIN, gin[j]);
            chk_rd(hcsc_pkg::ADDR_GAIN_RED, gout[j]);
        end
        wr(hcsc_pkg::ADDR_DUTY, 32'h0080_0000);
        chk_rd(hcsc_pkg::ADDR_DUTY, 32'hFF80_0000);
        duty = 24'h200000;
        wr(hcsc_pkg::ADDR_DUTY, {8'h00, duty});
        for (int j = 0; j < 24; j++) wr(hcsc_pkg::ADDR_CMD_BASE + 8'(4 * j), cmd(j));
        // scaling factor as a host would compute it for this tick and motor
        scale = 32'd1000000;
        wr(hcsc_pkg::ADDR_SCALE, scale);
        chk_rd(hcsc_pkg::ADDR_SCALE, scale);
        wr(hcsc_pkg::ADDR_CTRL, 32'h1);
        next_cyc = cyc + 4;
        for (int j = 0; j < 8; j++) step(1'b0, 70 + 10 * (j % 3), 1'b1, j >= 6);
        wr(hcsc_pkg::ADDR_CTRL, 32'h3);
        secm = 1;
        step(1'b0, 80, 1'b1, 1'b0);
        wr(hcsc_pkg::ADDR_SECT_PER, 32'h0);
        chk_rd(hcsc_pkg::ADDR_SECT_PER, 32'd40);
        scale = 32'hFFFF_FFFF;
        wr(hcsc_pkg::ADDR_SCALE, scale);
        step(1'b0, 90, 1'b1, 1'b0);
        // the turn-around edge uses the reverse table, since dir_d is set at once; its phases are not judged
        step(1'b1, 70, 1'b0, 1'b0);
        for (int j = 0; j < 4; j++) step(1'b1, 70 + 10 * j, 1'b1, 1'b0);
        duty = 24'h800000;
        wr(hcsc_pkg::ADDR_DUTY, {8'h00, duty});
        repeat (4) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        chk_ph();
        conclude();
    end
endmodule

// *** design/hcsc_pkg.sv ***
package hcsc_pkg;

    // signed 1.23 fractions; time is kept as plain unsigned ticks
    localparam int FRAC_W = 24;
    typedef logic signed [FRAC_W-1:0] hcsc_fract_t;
    typedef logic [23:0] hcsc_ticks_t;
    localparam hcsc_fract_t FRAC_MAX = 24'h7FFFFF;
    localparam hcsc_fract_t FRAC_MIN = 24'h800000;

    // tick base: one tick every TICK_PERIOD_NS of a CLK_PERIOD_NS clock
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int TICK_DIV_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SCALE = 8'h08;
    localparam logic [7:0] ADDR_REV_PER = 8'h0C;
    localparam logic [7:0] ADDR_SECT_PER = 8'h10;
    localparam logic [7:0] ADDR_LAST_EDGE = 8'h14;
    localparam logic [7:0] ADDR_SPEED = 8'h18;
    localparam logic [7:0] ADDR_DUTY = 8'h1C;
    localparam logic [7:0] ADDR_GAIN = 8'h20;
    localparam logic [7:0] ADDR_GAIN_RED = 8'h24;
    localparam logic [7:0] ADDR_CMD_BASE = 8'h40;
    localparam int NUM_CMDS = 24;

    // field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SECT_BIT = 1;
    localparam int STAT_DIR_BIT = 0;
    localparam int STAT_SECT_LSB = 1;
    localparam int STAT_BUSY_BIT = 4;
    localparam int GAIN_FMT_BIT = 24;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SCALE_RESET = 32'h0000_0000;

    // channel commutation states
    typedef enum logic [1:0] {
        CH_ON_HIGH = 2'h0,
        CH_ON_LOW = 2'h1,
        CH_OFF_LOW = 2'h2,
        CH_OFF_HIGH = 2'h3
    } hcsc_chst_e;

    localparam logic [7:0] OPT_DUTY_POS = 8'h00;
    localparam logic [7:0] OPT_DUTY_INVERT_SIGN = 8'h01;

    typedef struct packed {
        logic [7:0] base_ch;
        logic [7:0] base_st;
        logic [7:0] comp_st;
        logic [7:0] option;
    } hcsc_cmd_s;

    typedef struct packed {
        hcsc_chst_e base_st;
        hcsc_chst_e comp_st;
        logic duty_invert_sign;
        hcsc_fract_t duty;
    } hcsc_phase_s;

    typedef enum logic [1:0] {
        COM_IDLE = 2'b00,
        COM_OFF = 2'b01,
        COM_ON = 2'b11
    } hcsc_com_e;

    localparam int DIV_STEPS = 32;
    localparam logic [2:0] SECT_BAD = 3'h7;
    localparam logic [2:0] SECT_LAST = 3'h5;

    function automatic hcsc_fract_t hcsc_sat_neg(hcsc_fract_t d);
        return (d == FRAC_MIN) ? FRAC_MAX : -d;
    endfunction

    // sector number along increasing electrical angle
    function automatic logic [2:0] hcsc_sector(logic [2:0] h);
        case (h)
            3'h1: return 3'h0;
            3'h3: return 3'h1;
            3'h2: return 3'h2;
            3'h6: return 3'h3;
            3'h4: return 3'h4;
            3'h5: return 3'h5;
            default: return SECT_BAD;
        endcase
    endfunction

endpackage

// *** design/hcsc_top.sv ***
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
// Overview of operation
// - quantities are signed 1.23 fractions, 0x800000 is -1
// - 9.23 gain reduced to 9.15 or 1.23
// - speed from revolution period, option selects sector
// - sector period is ticks between consecutive transitions
// - revolution period measured same input, same edge
// - revolution period refreshed on every transition
// - speed equals scaling factor over period
// - each transition applies off command then on
// - command pair per input, edge and direction
// - command word holds four byte fields
// - channel state is one of four states
// - phase option keeps or negates duty
// - option applies now on, later if off
// - direction zero forward, nonzero reverse
// - every edge time stored, periods updated per sector
module hcsc_top #(
    parameter int NUM_PHASES = 3,
    parameter int TICK_DIV = hcsc_pkg::TICK_DIV_CYC
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // hall sensors
    input wire logic [2:0] hall_in,
    // phase channels and status
    output hcsc_pkg::hcsc_phase_s [NUM_PHASES-1:0] phase_out,
    output hcsc_pkg::hcsc_fract_t speed_out,
    output logic dir_out
);

    logic en_q;
    logic sect_sel_q;
    logic [31:0] scale_q;
    hcsc_pkg::hcsc_fract_t duty_q;
    logic [31:0] gain_q;
    logic [23:0] gain_red_q;
    logic gain_fmt_q;
    logic [31:0] cmd_tab_q [hcsc_pkg::NUM_CMDS];
    logic [15:0] tick_cnt_q;
    logic tick_en;
    hcsc_pkg::hcsc_ticks_t timer_q;
    logic [2:0] hall_q;
    logic [2:0] changed;
    logic [1:0] edge_ch;
    logic edge_rise;
    logic edge_evt;
    logic [2:0] slot;
    hcsc_pkg::hcsc_ticks_t stamp_q [6];
    hcsc_pkg::hcsc_ticks_t last_edge_q;
    hcsc_pkg::hcsc_ticks_t rev_period_q;
    hcsc_pkg::hcsc_ticks_t sect_period_q;
    hcsc_pkg::hcsc_ticks_t rev_calc;
    hcsc_pkg::hcsc_ticks_t sect_calc;
    hcsc_pkg::hcsc_ticks_t div_den;
    logic [2:0] sector_q;
    logic [2:0] sector_new;
    logic [2:0] sector_next;
    logic fwd_step;
    logic dir_q;
    logic dir_d;
    hcsc_pkg::hcsc_com_e com_q;
    logic [4:0] com_idx_q;
    hcsc_pkg::hcsc_cmd_s cmd;
    hcsc_pkg::hcsc_chst_e base_st_q [NUM_PHASES];
    hcsc_pkg::hcsc_chst_e comp_st_q [NUM_PHASES];
    logic [NUM_PHASES-1:0] duty_invert_sign_q;
    hcsc_pkg::hcsc_fract_t phase_duty_q [NUM_PHASES];
    logic div_busy_q;
    logic [5:0] div_cnt_q;
    hcsc_pkg::hcsc_ticks_t div_den_q;
    logic [31:0] div_num_q;
    logic [23:0] div_rem_q;
    logic [24:0] div_trial;
    logic div_ge;
    logic [31:0] div_quo;
    hcsc_pkg::hcsc_fract_t speed_q;
    logic [31:0] rdata_q;
    logic cmd_hit;
    logic [7:0] cmd_off;
    logic gain_in_range;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    // ---------------- register port ----------------
    assign cmd_off = reg_addr_in - hcsc_pkg::ADDR_CMD_BASE;
    assign cmd_hit = (reg_addr_in >= hcsc_pkg::ADDR_CMD_BASE)
        && (cmd_off < 8'(4 * hcsc_pkg::NUM_CMDS)) && (reg_addr_in[1:0] == 2'h0);
    assign gain_in_range = (reg_wdata_in[31:23] == {9{reg_wdata_in[23]}});

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            en_q <= hcsc_pkg::CTRL_RESET[hcsc_pkg::CTRL_EN_BIT];
            sect_sel_q <= hcsc_pkg::CTRL_RESET[hcsc_pkg::CTRL_SECT_BIT];
            scale_q <= hcsc_pkg::SCALE_RESET;
            duty_q <= 24'h000000;
        end else if (reg_wr_in) begin
            if (reg_addr_in == hcsc_pkg::ADDR_CTRL) begin
                en_q <= reg_wdata_in[hcsc_pkg::CTRL_EN_BIT];
                sect_sel_q <= reg_wdata_in[hcsc_pkg::CTRL_SECT_BIT];
            end
            if (reg_addr_in == hcsc_pkg::ADDR_SCALE) begin
                scale_q <= reg_wdata_in;
            end
            if (reg_addr_in == hcsc_pkg::ADDR_DUTY) begin
                duty_q <= reg_wdata_in[23:0];
            end
        end
    end

    // gain: 1.23 keeps full resolution when the value fits, else 9.15 keeps range
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            gain_q <= 32'h0000_0000;
            gain_red_q <= 24'h000000;
            gain_fmt_q <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == hcsc_pkg::ADDR_GAIN) begin
            gain_q <= reg_wdata_in;
            gain_fmt_q <= !gain_in_range;
            gain_red_q <= gain_in_range ? reg_wdata_in[23:0] : reg_wdata_in[31:8];
        end
    end

    // the table is software-written; reset does not clear storage
    always_ff @(posedge sys_clk_in) begin
        if (reg_wr_in && cmd_hit) begin
            cmd_tab_q[cmd_off[6:2]] <= reg_wdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            rdata_q <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            unique case (1'b1)
                reg_addr_in == hcsc_pkg::ADDR_CTRL:
                    rdata_q <= {30'h0, sect_sel_q, en_q};
                reg_addr_in == hcsc_pkg::ADDR_STATUS:
                    rdata_q <= {27'h0, div_busy_q, sector_q, dir_q};
                reg_addr_in == hcsc_pkg::ADDR_SCALE: rdata_q <= scale_q;
                reg_addr_in == hcsc_pkg::ADDR_REV_PER: rdata_q <= {8'h00, rev_period_q};
                reg_addr_in == hcsc_pkg::ADDR_SECT_PER: rdata_q <= {8'h00, sect_period_q};
                reg_addr_in == hcsc_pkg::ADDR_LAST_EDGE: rdata_q <= {8'h00, last_edge_q};
                reg_addr_in == hcsc_pkg::ADDR_SPEED: rdata_q <= {{8{speed_q[23]}}, speed_q};
                reg_addr_in == hcsc_pkg::ADDR_DUTY: rdata_q <= {{8{duty_q[23]}}, duty_q};
                reg_addr_in == hcsc_pkg::ADDR_GAIN: rdata_q <= gain_q;
                reg_addr_in == hcsc_pkg::ADDR_GAIN_RED: rdata_q <= {7'h00, gain_fmt_q, gain_red_q};
                cmd_hit: rdata_q <= cmd_tab_q[cmd_off[6:2]];
                default: rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end
    assign reg_rdata_out = rdata_q;

    // ---------------- tick timer base ----------------
    assign tick_en = (tick_cnt_q == 16'(TICK_DIV - 1));

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            tick_cnt_q <= 16'h0000;
            timer_q <= 24'h000000;
        end else begin
            tick_cnt_q <= tick_en ? 16'h0000 : tick_cnt_q + 16'h0001;
            if (tick_en) begin
                timer_q <= timer_q + 24'h000001;
            end
        end
    end

    // ---------------- hall position decoder ----------------
    // a new edge waits until the previous command pair is finished, so none is lost
    assign changed = hall_in ^ hall_q;
    assign edge_evt = en_q && (changed != 3'h0) && (com_q == hcsc_pkg::COM_IDLE);

    always_comb begin
        edge_ch = 2'h0;
        for (int i = 2; i >= 0; i--) begin
            if (changed[i]) begin
                edge_ch = 2'(i);
            end
        end
    end

    assign edge_rise = hall_in[edge_ch];
    assign slot = {edge_ch, 1'b0} + {2'b00, edge_rise};
    assign rev_calc = timer_q - stamp_q[slot];
    assign sect_calc = timer_q - last_edge_q;
    assign sector_new = hcsc_pkg::hcsc_sector(hall_in);
    assign sector_next = (sector_q == hcsc_pkg::SECT_LAST) ? 3'h0 : sector_q + 3'h1;
    assign fwd_step = (sector_new == sector_next);
    assign dir_d = (sector_new == hcsc_pkg::SECT_BAD || sector_q == hcsc_pkg::SECT_BAD)
        ? dir_q : !fwd_step;

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            hall_q <= 3'h0;
            last_edge_q <= 24'h000000;
            rev_period_q <= 24'h000000;
            sect_period_q <= 24'h000000;
            sector_q <= hcsc_pkg::SECT_BAD;
            dir_q <= 1'b0;
            for (int i = 0; i < 6; i++) begin
                stamp_q[i] <= 24'h000000;
            end
        end else if (!en_q) begin
            hall_q <= hall_in;
            sector_q <= sector_new;
        end else if (edge_evt) begin
            hall_q[edge_ch] <= hall_in[edge_ch];
            last_edge_q <= timer_q;
            stamp_q[slot] <= timer_q;
            rev_period_q <= rev_calc;
            sect_period_q <= sect_calc;
            sector_q <= sector_new;
            dir_q <= dir_d;
        end
    end
    assign dir_out = dir_q;

    // ---------------- commutation ----------------
    // pair base index: direction, input, edge type; even entry off, odd entry on
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            com_q <= hcsc_pkg::COM_IDLE;
            com_idx_q <= 5'h00;
        end else begin
            unique case (com_q)
                hcsc_pkg::COM_IDLE: begin
                    if (edge_evt) begin
                        com_q <= hcsc_pkg::COM_OFF;
                        com_idx_q <= 5'((dir_d ? 12 : 0) + 4 * edge_ch + 2 * edge_rise);
                    end
                end
                hcsc_pkg::COM_OFF: com_q <= hcsc_pkg::COM_ON;
                hcsc_pkg::COM_ON: com_q <= hcsc_pkg::COM_IDLE;
                default: com_q <= hcsc_pkg::COM_IDLE;
            endcase
        end
    end

    assign cmd = hcsc_pkg::hcsc_cmd_s'(cmd_tab_q[com_idx_q | {4'h0, com_q == hcsc_pkg::COM_ON}]);

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            for (int p = 0; p < NUM_PHASES; p++) begin
                base_st_q[p] <= hcsc_pkg::CH_OFF_LOW;
                comp_st_q[p] <= hcsc_pkg::CH_OFF_LOW;
                duty_invert_sign_q[p] <= 1'b0;
            end
        end else if (com_q != hcsc_pkg::COM_IDLE) begin
            for (int p = 0; p < NUM_PHASES; p++) begin
                if (cmd.base_ch == 8'(p)) begin
                    base_st_q[p] <= hcsc_pkg::hcsc_chst_e'(cmd.base_st[1:0]);
                    comp_st_q[p] <= hcsc_pkg::hcsc_chst_e'(cmd.comp_st[1:0]);
                    // an option for a phase going off waits until it is switched on
                    if (com_q == hcsc_pkg::COM_ON) begin
                        duty_invert_sign_q[p] <= cmd.option[0];
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            for (int p = 0; p < NUM_PHASES; p++) begin
                phase_duty_q[p] <= 24'h000000;
            end
        end else begin
            for (int p = 0; p < NUM_PHASES; p++) begin
                phase_duty_q[p] <= duty_invert_sign_q[p] ? hcsc_pkg::hcsc_sat_neg(duty_q) : duty_q;
            end
        end
    end

    for (genvar p = 0; p < NUM_PHASES; p++) begin : g_phase
        assign phase_out[p] = '{base_st: base_st_q[p], comp_st: comp_st_q[p],
            duty_invert_sign: duty_invert_sign_q[p], duty: phase_duty_q[p]};
    end

    // ---------------- speed: scale / period, restoring divider ----------------
    assign div_den = sect_sel_q ? sect_calc : rev_calc;
    assign div_trial = {div_rem_q, div_num_q[31]};
    assign div_ge = (div_trial >= {1'b0, div_den_q});
    assign div_quo = {div_num_q[30:0], div_ge};

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            div_busy_q <= 1'b0;
            div_cnt_q <= 6'h00;
            div_den_q <= 24'h000000;
            div_num_q <= 32'h0000_0000;
            div_rem_q <= 24'h000000;
            speed_q <= 24'h000000;
        end else if (edge_evt) begin
            div_den_q <= div_den;
            div_num_q <= scale_q;
            div_rem_q <= 24'h000000;
            div_cnt_q <= 6'(hcsc_pkg::DIV_STEPS);
            div_busy_q <= (div_den != 24'h000000);
            if (div_den == 24'h000000) begin
                speed_q <= hcsc_pkg::FRAC_MAX;
            end
        end else if (div_busy_q) begin
            div_num_q <= div_quo;
            div_rem_q <= div_ge ? 24'(div_trial - {1'b0, div_den_q}) : div_trial[23:0];
            div_cnt_q <= div_cnt_q - 6'h01;
            if (div_cnt_q == 6'h01) begin
                div_busy_q <= 1'b0;
                // quotients beyond full scale clip rather than wrap
                speed_q <= (div_quo > 32'h007F_FFFF) ? hcsc_pkg::FRAC_MAX : div_quo[23:0];
            end
        end
    end
    assign speed_out = speed_q;

    // ---------------- checks ----------------
    AST_LAST_EDGE: assert property (edge_evt |=> last_edge_q == $past(timer_q))
        else $error("last edge time not captured");
    AST_SECT_PERIOD: assert property (edge_evt |=>
        sect_period_q == 24'($past(timer_q) - $past(last_edge_q)))
        else $error("sector period wrong");
    AST_REV_PERIOD: assert property (edge_evt |=>
        rev_period_q == 24'($past(timer_q) - $past(stamp_q[slot])) && stamp_q[$past(slot)] == $past(timer_q))
        else $error("revolution period wrong");
    AST_DIR_FWD: assert property (edge_evt && fwd_step && sector_q != hcsc_pkg::SECT_BAD
        |=> !dir_q)
        else $error("forward step not reported as zero");
    AST_CMD_PAIR: assert property (edge_evt |=> com_q == hcsc_pkg::COM_OFF
        ##1 com_q == hcsc_pkg::COM_ON && com_idx_q[0] == 1'b0 ##1 com_q == hcsc_pkg::COM_IDLE)
        else $error("off/on command pair not issued in order");
    AST_SRC_SEL: assert property (edge_evt && !sect_sel_q |=> div_den_q == $past(rev_calc))
        else $error("divider not using revolution period");
    AST_SAT_ZERO: assert property (edge_evt && div_den == 24'h000000
        |=> speed_q == hcsc_pkg::FRAC_MAX)
        else $error("zero period did not saturate speed");
    AST_SPEED_POS: assert property (speed_q[23] == 1'b0)
        else $error("speed left positive fraction range");
    AST_GAIN_RED: assert property (reg_wr_in && reg_addr_in == hcsc_pkg::ADDR_GAIN
        && gain_in_range |=> !gain_fmt_q && gain_red_q == $past(reg_wdata_in[23:0]))
        else $error("in-range gain not kept as 1.23");
    AST_OPT_OFF: assert property (com_q == hcsc_pkg::COM_OFF && cmd.base_ch == 8'h00
        |=> $stable(duty_invert_sign_q[0]))
        else $error("off command changed duty sign at once");
    AST_NEG_DUTY: assert property (duty_invert_sign_q[0] && $stable(duty_q)
        |=> phase_duty_q[0] == hcsc_pkg::hcsc_sat_neg($past(duty_q))
        && phase_duty_q[0] != 24'h800000)
        else $error("negated duty wrong");

    COV_FWD: cover property (edge_evt && fwd_step);
    COV_REV: cover property (edge_evt ##1 dir_q);
    COV_SAT: cover property (div_busy_q && div_cnt_q == 6'h01 && div_quo > 32'h007F_FFFF);
    COV_GAIN_WIDE: cover property (gain_fmt_q);

endmodule
